/* File: shared/charge_power_regs.svh */
// Purpose: Offsets, field positions, reset values for the id, charge counter and power-control words
// Assumes: 24-bit register words, addresses are word indexes
// Notes:   Included by the register bank and by the checker
`ifndef CHARGE_POWER_REGS_SVH
`define CHARGE_POWER_REGS_SVH

`define CPR_ADDR_W            6
`define CPR_DATA_W            24
// Word indexes
`define CPR_OFS_IDENTITY      6'h07
`define CPR_OFS_UNUSED_A      6'h08
`define CPR_OFS_CC_CONTROL    6'h09
`define CPR_OFS_CC_OUTPUT     6'h0a
`define CPR_OFS_UNUSED_B      6'h0b
`define CPR_OFS_UNUSED_C      6'h0c
`define CPR_OFS_POWER_CTRL0   6'h0d
// Identity word fields
`define CPR_ID_REV_LSB        0
`define CPR_ID_GEN_LSB        6
`define CPR_ID_CODE_LSB       13
// Charge counter control word fields
`define CPR_CC_RUN_BIT        0
`define CPR_CC_CLEAR_BIT      1
`define CPR_CC_DITHER_BIT     2
`define CPR_CC_DOC_OFF_BIT    3
`define CPR_CC_ACAL_BIT       4
`define CPR_CC_FAULT_BIT      7
`define CPR_CC_RESULT_LSB     8
`define CPR_CC_RESULT_MSB     23
// Charge counter output word
`define CPR_ACC_OUT_MSB       14
`define CPR_ACC_OUT_RESET     15'h0001
// Power control word 0 fields
`define CPR_PC_CUT_ON_BIT     0
`define CPR_PC_TALLY_BIT      1
`define CPR_PC_WARM_BIT       2
`define CPR_PC_USER_OFF_BIT   3
`define CPR_PC_BACKUP_BIT     4
`define CPR_PC_CLK_UOFF_BIT   5
`define CPR_PC_CLK_ON_BIT     6
`define CPR_PC_GLB_RST_BIT    7
`define CPR_PC_THERM_BIT      8
`define CPR_PC_CUT_OK_BIT     9
`define CPR_PC_CLK_ON_RESET   1'b1

`endif

/* File: shared/charge_power_pkg.sv */
// Purpose: Types shared by the charge counter and power-control register bank
// Assumes: Constants live in charge_power_regs.svh
// Notes:   Structs carry the writable fields as grouped bundles
package charge_power_pkg;

    // Writable charge counter controls
    typedef struct packed {
        logic analog_offset_cal_mode;     // Analog calibration request
        logic digital_offset_cancel_off;  // Skip offset subtraction
        logic counter_dither_on;          // Dither request to front end
        logic counter_run;                // Accumulate while set
    } cc_ctrl_t;

    // Power control word 0, low ten bits
    typedef struct packed {
        logic cut_timer_not_expired;      // Cleared by hardware on timer expiry
        logic thermal_threshold_select;   // System-reset domain
        logic global_reset_select;        // Raw select bit
        logic proc_slow_clock_on;         // Slow clock enable
        logic keep_clock_in_user_off;     // Clock stays up in user off
        logic keep_backup_alive;          // Backup supply and clock always on
        logic user_off_command;           // System-reset domain
        logic warm_start_on;              // Warm start enable
        logic power_cut_tally_on;         // Count power cuts
        logic power_cut_on;               // Power cut enable
    } pc0_t;

endpackage : charge_power_pkg

/* File: hdl/charge_power_regs.sv */
// Purpose: Identity, charge counter and power-control register bank of the power device
// Assumes: Serial control port decodes frames into one-cycle word reads and writes on clk_i
// Notes:   reset_n_i is the real-time-clock power-on reset; sys_reset_n_i is the system reset pin
//
// Operation
// - Identity word constant, read-only, reset-independent
// - Clear bit empties count, self-clears
// - Bit 2 steers dithering, resets zero
// - Bit 3 bypasses digital offset cancellation
// - Bit 4 enters analog calibration mode
// - Bits 5-6 read zero, ignore writes
// - Fault bit flags invalid 16-bit result
// - Output word 15 bits, resets to one
// - Power-cut tally enable, kept over system reset
// - User-off command cleared by system reset
// - Backup bit keeps supply and clock on
// - Clock stays running during user off
// - Bit 7 governs global reset on button
// - Thermal threshold select, system-reset cleared
// - Boot-written flag cleared on cut timer expiry
// - Global reset polarity depends on variant
`include "charge_power_regs.svh"

module charge_power_regs #(
    parameter logic [4:0]  REVISION        = 5'h01,  // Arbitrary value
    parameter logic [2:0]  GENERATION      = 3'h5,   // Arbitrary value
    parameter logic [5:0]  IN_GEN_CODE     = 6'h0b,  // Arbitrary value
    parameter bit          GLB_RST_ACT_LOW = 1'b1,   // Variant strap: 1 = function on when bit is 0
    parameter int          RESULT_W        = 16,
    parameter int          ACC_OUT_W       = 15
) (
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    sys_reset_n_i,
    input  wire logic [`CPR_ADDR_W-1:0]  reg_addr_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    input  wire logic [`CPR_DATA_W-1:0]  reg_wdata_i,
    output logic      [`CPR_DATA_W-1:0]  reg_rdata_o,
    input  wire logic                    cc_sample_i,
    input  wire logic [RESULT_W-1:0]     cc_delta_i,
    input  wire logic [RESULT_W-1:0]     cc_offset_i,
    input  wire logic                    cut_timer_expired_i,
    input  wire logic                    user_off_state_i,
    output logic                         counter_dither_on_o,
    output logic                         analog_offset_cal_mode_o,
    output logic                         counter_running_o,
    output logic                         power_cut_on_o,
    output logic                         power_cut_tally_on_o,
    output logic                         warm_start_on_o,
    output logic                         user_off_command_o,
    output logic                         backup_rtc_supply_on_o,
    output logic                         proc_slow_clock_out_on_o,
    output logic                         global_reset_on_o,
    output logic                         thermal_threshold_select_o
);

    // System reset pin synchroniser; stage one feeds only stage two
    logic        sys_rst_meta_q;
    logic        sys_rst_sync_q;
    wire  logic  sys_reset_active = ~sys_rst_sync_q;

    // Register state
    charge_power_pkg::cc_ctrl_t  cc_ctrl_q, cc_ctrl_d;   // Counter controls
    charge_power_pkg::pc0_t      pc0_q, pc0_d;           // Power control word 0
    logic                        fault_q, fault_d;       // Result no longer valid
    logic [RESULT_W-1:0]         result_q, result_d;     // Signed accumulated count
    logic [ACC_OUT_W-1:0]        acc_out_q, acc_out_d;   // Sample tally output

    // Address decode
    wire logic hit_cc_ctrl = (reg_addr_i == `CPR_OFS_CC_CONTROL);
    wire logic hit_pc0     = (reg_addr_i == `CPR_OFS_POWER_CTRL0);
    wire logic wr_cc_ctrl  = reg_wr_i & hit_cc_ctrl;
    wire logic wr_pc0      = reg_wr_i & hit_pc0;

    // Clear strobe acts in the write cycle only, so the bit reads back zero
    wire logic cc_clear = wr_cc_ctrl & reg_wdata_i[`CPR_CC_CLEAR_BIT];

    // Offset-corrected sample; the bypass exists for characterising raw offset
    wire logic [RESULT_W-1:0] sample_corr =
        cc_ctrl_q.digital_offset_cancel_off ? cc_delta_i : (cc_delta_i - cc_offset_i);
    wire logic [RESULT_W-1:0] sum_next = result_q + sample_corr;
    // Signed overflow: operands agree in sign, sum does not
    wire logic sum_ovf = (result_q[RESULT_W-1] == sample_corr[RESULT_W-1]) &
                         (sum_next[RESULT_W-1] != result_q[RESULT_W-1]);
    wire logic accumulate = cc_ctrl_q.counter_run & cc_sample_i;

    // Identity word, a pure constant with no flop behind it
    wire logic [`CPR_DATA_W-1:0] identity_word =
        (`CPR_DATA_W'(REVISION)    << `CPR_ID_REV_LSB) |
        (`CPR_DATA_W'(GENERATION)  << `CPR_ID_GEN_LSB) |
        (`CPR_DATA_W'(IN_GEN_CODE) << `CPR_ID_CODE_LSB);

    // Read views; bits 5-6 and every unlisted position stay zero
    wire logic [`CPR_DATA_W-1:0] cc_ctrl_word =
        {result_q, fault_q, 2'b00, cc_ctrl_q.analog_offset_cal_mode,
         cc_ctrl_q.digital_offset_cancel_off, cc_ctrl_q.counter_dither_on,
         1'b0, cc_ctrl_q.counter_run};
    wire logic [`CPR_DATA_W-1:0] cc_out_word =
        {{(`CPR_DATA_W-ACC_OUT_W){1'b0}}, acc_out_q};
    wire logic [`CPR_DATA_W-1:0] pc0_word =
        {{(`CPR_DATA_W-10){1'b0}}, pc0_q};

    // Read mux; unused and unmapped words read zero
    function automatic logic [`CPR_DATA_W-1:0] read_mux(input logic [`CPR_ADDR_W-1:0] a,
                                                         input logic [`CPR_DATA_W-1:0] idw,
                                                         input logic [`CPR_DATA_W-1:0] ccw,
                                                         input logic [`CPR_DATA_W-1:0] cow,
                                                         input logic [`CPR_DATA_W-1:0] pcw);
        logic [`CPR_DATA_W-1:0] r;
        r = '0;
        if (a == `CPR_OFS_IDENTITY)
            r = idw;
        else if (a == `CPR_OFS_CC_CONTROL)
            r = ccw;
        else if (a == `CPR_OFS_CC_OUTPUT)
            r = cow;
        else if (a == `CPR_OFS_POWER_CTRL0)
            r = pcw;
        return r;
    endfunction : read_mux

    wire logic [`CPR_DATA_W-1:0] rd_word =
        read_mux(reg_addr_i, identity_word, cc_ctrl_word, cc_out_word, pc0_word);

    // Counter controls: plain read/write fields
    always_comb begin
        cc_ctrl_d = cc_ctrl_q;
        if (wr_cc_ctrl) begin
            cc_ctrl_d.counter_run               = reg_wdata_i[`CPR_CC_RUN_BIT];
            cc_ctrl_d.counter_dither_on         = reg_wdata_i[`CPR_CC_DITHER_BIT];
            cc_ctrl_d.digital_offset_cancel_off = reg_wdata_i[`CPR_CC_DOC_OFF_BIT];
            cc_ctrl_d.analog_offset_cal_mode    = reg_wdata_i[`CPR_CC_ACAL_BIT];
        end
    end

    // Result, fault and sample tally
    always_comb begin
        result_d  = result_q;
        acc_out_d = acc_out_q;
        fault_d   = fault_q;
        // Software may write the fault bit; a new fault in the same cycle wins
        if (wr_cc_ctrl)
            fault_d = reg_wdata_i[`CPR_CC_FAULT_BIT];
        if (cc_clear) begin
            result_d  = '0;
            acc_out_d = `CPR_ACC_OUT_RESET;
        end else if (accumulate) begin
            result_d  = sum_next;
            acc_out_d = acc_out_q + ACC_OUT_W'(1);
            if (sum_ovf)
                fault_d = 1'b1;
        end
    end

    // Power control word 0 next value
    always_comb begin
        pc0_d = pc0_q;
        if (wr_pc0) begin
            pc0_d.power_cut_on             = reg_wdata_i[`CPR_PC_CUT_ON_BIT];
            pc0_d.power_cut_tally_on       = reg_wdata_i[`CPR_PC_TALLY_BIT];
            pc0_d.warm_start_on            = reg_wdata_i[`CPR_PC_WARM_BIT];
            pc0_d.user_off_command         = reg_wdata_i[`CPR_PC_USER_OFF_BIT];
            pc0_d.keep_backup_alive        = reg_wdata_i[`CPR_PC_BACKUP_BIT];
            pc0_d.keep_clock_in_user_off   = reg_wdata_i[`CPR_PC_CLK_UOFF_BIT];
            pc0_d.proc_slow_clock_on       = reg_wdata_i[`CPR_PC_CLK_ON_BIT];
            pc0_d.global_reset_select      = reg_wdata_i[`CPR_PC_GLB_RST_BIT];
            pc0_d.thermal_threshold_select = reg_wdata_i[`CPR_PC_THERM_BIT];
            pc0_d.cut_timer_not_expired    = reg_wdata_i[`CPR_PC_CUT_OK_BIT];
        end
        // Expiry beats a same-cycle write so the evidence is never lost
        if (cut_timer_expired_i)
            pc0_d.cut_timer_not_expired = 1'b0;
        // System-reset bits clear whenever the synchronised reset is active
        if (sys_reset_active) begin
            pc0_d.user_off_command         = 1'b0;
            pc0_d.thermal_threshold_select = 1'b0;
        end
    end

    // Output decode
    wire logic backup_on_d = pc0_d.keep_backup_alive;
    wire logic slow_clk_d  = pc0_d.keep_backup_alive |
                             (pc0_d.proc_slow_clock_on &
                              (~user_off_state_i | pc0_d.keep_clock_in_user_off));
    wire logic glb_rst_d   = pc0_d.global_reset_select ^ GLB_RST_ACT_LOW;

    // Synchroniser for the system reset pin
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_rst_meta_q <= 1'b0;
            sys_rst_sync_q <= 1'b0;
        end else begin
            sys_rst_meta_q <= sys_reset_n_i;
            sys_rst_sync_q <= sys_rst_meta_q;
        end
    end

    // Power-on reset domain: reset_n_i resets these; system reset clears only the pc0_q user-off and thermal bits
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cc_ctrl_q <= '0;
            fault_q   <= 1'b0;
            result_q  <= '0;
            acc_out_q <= `CPR_ACC_OUT_RESET;
            pc0_q     <= charge_power_pkg::pc0_t'(10'h040);
        end else begin
            cc_ctrl_q <= cc_ctrl_d;
            fault_q   <= fault_d;
            result_q  <= result_d;
            acc_out_q <= acc_out_d;
            pc0_q     <= pc0_d;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o                <= '0;
            counter_dither_on_o        <= 1'b0;
            analog_offset_cal_mode_o   <= 1'b0;
            counter_running_o          <= 1'b0;
            power_cut_on_o             <= 1'b0;
            power_cut_tally_on_o       <= 1'b0;
            warm_start_on_o            <= 1'b0;
            user_off_command_o         <= 1'b0;
            backup_rtc_supply_on_o     <= 1'b0;
            proc_slow_clock_out_on_o   <= `CPR_PC_CLK_ON_RESET;
            global_reset_on_o          <= GLB_RST_ACT_LOW;
            thermal_threshold_select_o <= 1'b0;
        end else begin
            if (reg_rd_i)
                reg_rdata_o <= rd_word;
            counter_dither_on_o        <= cc_ctrl_d.counter_dither_on;
            analog_offset_cal_mode_o   <= cc_ctrl_d.analog_offset_cal_mode;
            counter_running_o          <= cc_ctrl_d.counter_run;
            power_cut_on_o             <= pc0_d.power_cut_on;
            power_cut_tally_on_o       <= pc0_d.power_cut_tally_on;
            warm_start_on_o            <= pc0_d.warm_start_on;
            user_off_command_o         <= pc0_d.user_off_command;
            backup_rtc_supply_on_o     <= backup_on_d;
            proc_slow_clock_out_on_o   <= slow_clk_d;
            global_reset_on_o          <= glb_rst_d;
            thermal_threshold_select_o <= pc0_d.thermal_threshold_select;
        end
    end

endmodule : charge_power_regs

/* File: bench/charge_power_checker.sv */
// Purpose: Concurrent checks on the charge counter and power-control register bank
// Assumes: Reads answer on the cycle after the strobe
// Notes:   Watches the top ports only, bound below
`include "charge_power_regs.svh"
module charge_power_checker #(
    parameter logic [4:0] REVISION        = 5'h01,
    parameter logic [2:0] GENERATION      = 3'h5,
    parameter logic [5:0] IN_GEN_CODE     = 6'h0b,
    parameter bit         GLB_RST_ACT_LOW = 1'b1
) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        sys_reset_n_i,
    input wire logic [5:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [23:0] reg_wdata_i,
    input wire logic [23:0] reg_rdata_o,
    input wire logic        counter_dither_on_o,
    input wire logic        analog_offset_cal_mode_o,
    input wire logic        counter_running_o,
    input wire logic        power_cut_tally_on_o,
    input wire logic        user_off_command_o,
    input wire logic        backup_rtc_supply_on_o,
    input wire logic        proc_slow_clock_out_on_o,
    input wire logic        global_reset_on_o,
    input wire logic        thermal_threshold_select_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Strobe decodes, one per watched word and access direction
    wire logic wr_cc  = reg_wr_i && (reg_addr_i == `CPR_OFS_CC_CONTROL);
    wire logic wr_pc  = reg_wr_i && (reg_addr_i == `CPR_OFS_POWER_CTRL0);
    wire logic rd_id  = reg_rd_i && (reg_addr_i == `CPR_OFS_IDENTITY);
    wire logic rd_cc  = reg_rd_i && (reg_addr_i == `CPR_OFS_CC_CONTROL);
    wire logic rd_out = reg_rd_i && (reg_addr_i == `CPR_OFS_CC_OUTPUT);
    // Unused words and any index outside the map must read zero
    wire logic rd_nil = reg_rd_i && ((reg_addr_i inside {6'h08, 6'h0b, 6'h0c}) || reg_addr_i < 6'h07
                                     || reg_addr_i > 6'h0d);
    // Identity word; the gaps between fields are zero
    wire logic [23:0] id_exp = {5'h00, IN_GEN_CODE, 4'h0, GENERATION, 1'b0, REVISION};

    a_run_follows: assert property (wr_cc |=> counter_running_o == $past(reg_wdata_i[0]))
        else $error("run output does not follow write");
    a_dither_follows: assert property (wr_cc |=> counter_dither_on_o == $past(reg_wdata_i[2]))
        else $error("dither output does not follow write");
    a_acal_follows: assert property (wr_cc |=> analog_offset_cal_mode_o == $past(reg_wdata_i[4]))
        else $error("calibration output does not follow write");
    a_tally_follows: assert property (wr_pc |=> power_cut_tally_on_o == $past(reg_wdata_i[1]))
        else $error("tally output does not follow write");
    a_global_reset_polarity: assert property (
        wr_pc |=> global_reset_on_o == ($past(reg_wdata_i[7]) ^ GLB_RST_ACT_LOW))
        else $error("global reset output has wrong polarity");
    a_backup_keeps_clock: assert property (backup_rtc_supply_on_o |-> proc_slow_clock_out_on_o)
        else $error("slow clock off while backup bit set");
    a_sysrst_clears: assert property (
        (!sys_reset_n_i) [*4] |-> !user_off_command_o && !thermal_threshold_select_o)
        else $error("system reset did not clear its bits");
    a_id_read: assert property (rd_id |=> reg_rdata_o == id_exp)
        else $error("identity word mismatch");
    a_unused_read: assert property (rd_nil |=> reg_rdata_o == 24'h000000)
        else $error("unused word read nonzero");
    a_reserved_zero: assert property (rd_cc |=> reg_rdata_o[6:5] == 2'b00 && !reg_rdata_o[1])
        else $error("reserved or clear bit read nonzero");
    a_output_upper: assert property (rd_out |=> reg_rdata_o[23:15] == 9'h000)
        else $error("output word upper bits nonzero");

    c_cc_write: cover property (wr_cc);
    c_id_read: cover property (rd_id);
    c_sys_reset: cover property ((!sys_reset_n_i) [*4]);
endmodule : charge_power_checker

bind charge_power_regs charge_power_checker #(.REVISION(REVISION), .GENERATION(GENERATION),
    .IN_GEN_CODE(IN_GEN_CODE), .GLB_RST_ACT_LOW(GLB_RST_ACT_LOW)) checker_i (.*);

/* File: bench/charge_front_end_model.sv */
// Purpose: Coulomb counter front end feeding samples and a digital offset
// Assumes: One sample pulse per call
// Notes:   Delta is scrambled once the pulse has gone, so stale data never looks valid
module charge_front_end_model (
    input  wire logic        clk_i,
    output logic             cc_sample_o,
    output logic [15:0]      cc_delta_o,
    output logic [15:0]      cc_offset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cc_sample_o = 1'b0;
        cc_delta_o  = 16'h5a5a;
        cc_offset_o = 16'h0000;
    end
    // One-cycle sample; offset stays as a level
    task automatic send(input logic [15:0] d, input logic [15:0] o);
        @(posedge clk_i);
        cc_sample_o <= 1'b1;
        cc_delta_o  <= d;
        cc_offset_o <= o;
        @(posedge clk_i);
        cc_sample_o <= 1'b0;
        cc_delta_o  <= ~d;
    endtask : send
endmodule : charge_front_end_model

/* File: bench/tb_charge_power_regs.sv */
// Purpose: Self-checking bench for the charge counter and power-control register bank
// Assumes: Reads answer on the cycle after the strobe
// Notes:   Driver queues expected words; a monitor pops and compares them
module tb_charge_power_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary identity values
    localparam logic [23:0] ID_EXP = {5'h00, 6'h2a, 4'h0, 3'h2, 1'b0, 5'h13};
    logic clk_i = 1'b0, reset_n_i = 1'b0, sys_reset_n_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, pend = 1'b0;
    logic [5:0]  reg_addr_i = 6'h00;
    logic [23:0] reg_wdata_i = 24'h000000, reg_rdata_o, exp_q[$];
    logic cc_sample_i, cut_timer_expired_i = 1'b0, user_off_state_i = 1'b0;
    logic [15:0] cc_delta_i, cc_offset_i, d, o, r;
    logic counter_dither_on_o, analog_offset_cal_mode_o, counter_running_o, power_cut_on_o, power_cut_tally_on_o,
          warm_start_on_o, user_off_command_o, backup_rtc_supply_on_o, proc_slow_clock_out_on_o,
          global_reset_on_o, thermal_threshold_select_o;
    string name_q[$];
    int err_count = 0, n_checks = 0, seed = 89749;

    charge_power_regs #(.REVISION(5'h13), .GENERATION(3'h2), .IN_GEN_CODE(6'h2a)) charge_power_regs_i (.*);
    charge_front_end_model charge_front_end_model_i (.clk_i(clk_i), .cc_sample_o(cc_sample_i),
        .cc_delta_o(cc_delta_i), .cc_offset_o(cc_offset_i));

    always #5 clk_i = ~clk_i;

    task automatic cmp_word(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit
    // One-cycle strobes, a free edge between accesses
    task automatic wr(input logic [5:0] a, input logic [23:0] v);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [23:0] e);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        exp_q.push_back(e);
        name_q.push_back($sformatf("word %h", a));
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Monitor: read data is settled half a cycle after the answering edge
    always @(posedge clk_i) pend <= reg_rd_i;
    always @(negedge clk_i) begin
        if (pend && exp_q.size() > 0) begin
            cmp_word(name_q.pop_front(), exp_q.pop_front(), reg_rdata_o);
        end
    end

    // Watchdog, far beyond the roughly 125 cycles the tests take
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        cmp_bit("slow clock", 1'b1, proc_slow_clock_out_on_o);
        cmp_bit("global reset", 1'b1, global_reset_on_o);
        rd(6'h07, ID_EXP);
        rd(6'h09, 24'h000000);
        rd(6'h0a, 24'h000001);
        rd(6'h0d, 24'h000040);
        rd(6'h3f, 24'h000000);
        // Read-only and unused words ignore writes
        for (int a = 7; a <= 12; a++) if (a != 9) wr(6'(a), 24'hffffff);
        rd(6'h07, ID_EXP);
        rd(6'h08, 24'h000000);
        rd(6'h0a, 24'h000001);
        rd(6'h0b, 24'h000000);
        rd(6'h0c, 24'h000000);
        $display("test reset and read-only done");
        // All ones: clear self-clears, reserved stays zero, result is read-only
        wr(6'h09, 24'hffffff);
        cmp_bit("dither", 1'b1, counter_dither_on_o);
        cmp_bit("analog cal", 1'b1, analog_offset_cal_mode_o);
        rd(6'h09, 24'h00009d);
        wr(6'h09, 24'h000001);
        d = 16'($random(seed)) & 16'h3fff;
        o = 16'($random(seed)) & 16'h00ff;
        charge_front_end_model_i.send(d, o);
        r = d - o;
        rd(6'h09, {r, 8'h01});
        rd(6'h0a, 24'h000002);
        // Bypass the offset, then stop and show samples are ignored
        wr(6'h09, 24'h000009);
        d = 16'($random(seed)) & 16'h3fff;
        charge_front_end_model_i.send(d, o);
        r = r + d;
        rd(6'h09, {r, 8'h09});
        wr(6'h09, 24'h000008);
        charge_front_end_model_i.send(16'h1234, o);
        rd(6'h09, {r, 8'h08});
        wr(6'h09, 24'h000002);
        rd(6'h09, 24'h000000);
        rd(6'h0a, 24'h000001);
        $display("test counter done");
        wr(6'h0d, 24'h0003ff);
        rd(6'h0d, 24'h0003ff);
        cmp_bit("global reset", 1'b0, global_reset_on_o);
        cmp_bit("backup", 1'b1, backup_rtc_supply_on_o);
        cmp_bit("user off", 1'b1, user_off_command_o);
        cmp_bit("thermal", 1'b1, thermal_threshold_select_o);
        @(posedge clk_i) user_off_state_i <= 1'b1;
        wr(6'h0d, 24'h000040);
        cmp_bit("slow clock", 1'b0, proc_slow_clock_out_on_o);
        wr(6'h0d, 24'h000060);
        cmp_bit("slow clock", 1'b1, proc_slow_clock_out_on_o);
        @(posedge clk_i) user_off_state_i <= 1'b0;
        // Timer expiry clears the boot flag
        wr(6'h0d, 24'h000240);
        @(posedge clk_i) cut_timer_expired_i <= 1'b1;
        @(posedge clk_i) cut_timer_expired_i <= 1'b0;
        rd(6'h0d, 24'h000040);
        // Expiry held from the cycle before to the cycle after a write that sets the flag leaves it clear
        @(posedge clk_i) cut_timer_expired_i <= 1'b1;
        wr(6'h0d, 24'h000240);
        @(posedge clk_i) cut_timer_expired_i <= 1'b0;
        rd(6'h0d, 24'h000040);
        $display("test power control done");
        // System reset clears only the bits in its own domain
        wr(6'h0d, 24'h0001ff);
        wr(6'h09, 24'h000015);
        @(posedge clk_i) sys_reset_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        sys_reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(6'h0d, 24'h0000f7);
        rd(6'h09, 24'h000015);
        cmp_bit("user off", 1'b0, user_off_command_o);
        cmp_bit("thermal", 1'b0, thermal_threshold_select_o);
        cmp_bit("tally", 1'b1, power_cut_tally_on_o);
        cmp_bit("cut enable", 1'b1, power_cut_on_o);
        cmp_bit("warm start", 1'b1, warm_start_on_o);
        $display("test system reset done");
        repeat (3) @(posedge clk_i);
        report_and_stop();
    end
endmodule : tb_charge_power_regs
